// ---- design/pmic_status_defines.vh ----
`ifndef PMIC_STATUS_DEFINES_VH
`define PMIC_STATUS_DEFINES_VH

// ****************************************
// register offsets on the serial bus
// ****************************************
`define EVT_REG_OFFSET 8'h02
`define STAT_REG_OFFSET 8'h03

// ****************************************
// event register fields
// ****************************************
`define EVT_BIT_INPUT_IRQ_EN 7
`define EVT_BIT_TOUCH_IRQ_EN 6
`define EVT_BIT_BUTTON_IRQ_EN 5
`define EVT_BIT_TOUCH_FLAG 3
`define EVT_BIT_BUTTON_FLAG 2
`define EVT_BIT_APPLIED_FLAG 1
`define EVT_BIT_REMOVED_FLAG 0
`define EVT_FLAG_MASK 8'h0f
`define EVT_IRQ_EN_MASK 8'he0
`define EVT_RESET 8'h00

// ****************************************
// charger status fields
// ****************************************
`define STAT_BIT_THERMAL_REG 7
`define STAT_BIT_PATH_LOOP 6
`define STAT_BIT_THERMAL_SUSP 5
`define STAT_BIT_TERM_CURRENT 4
`define STAT_BIT_UNUSED 3
`define STAT_BIT_CHG_TIMEOUT 2
`define STAT_BIT_PRECHG_TIMEOUT 1
`define STAT_BIT_TEMP_FAULT 0
`define STAT_RESET 8'h00

// ****************************************
// serial slave
// ****************************************
`define DEV_ADDR_RESET 7'h2a
`define PTR_RESET 8'h00
`define UNMAPPED_READ 8'h00
`define BITS_PER_BYTE 4'h8

`endif

// ---- design/pin_sync.v ----
`timescale 1ns/10ps

module pin_sync #(
	parameter W = 12
) (
	// clock
	input wire CLK,
	input wire RST,
	input wire CE,
	// pins
	input wire [W-1:0] D,
	output wire [W-1:0] Q
);

// ****************************************
// two-flop synchroniser per pin
// ****************************************
genvar i;
generate
	for (i = 0; i < W; i = i + 1) begin : g_bit
		reg meta_r;
		reg sync_r;
		always @(posedge CLK) begin
			if (RST) begin
				meta_r <= 1'b0;
				sync_r <= 1'b0;
			end else if (CE) begin
				meta_r <= D[i];
				sync_r <= meta_r;
			end
		end
		assign Q[i] = sync_r;
	end
endgenerate

endmodule // pin_sync

// ---- design/pmic_status_regs.v ----
`timescale 1ns/10ps
`include "pmic_status_defines.vh"

module pmic_status_regs #(
	parameter [6:0] DEV_ADDR = `DEV_ADDR_RESET, // arbitrary value
	parameter PB_ACTIVE_HIGH = 0
) (
	// clock and reset
	input wire CLK,
	input wire RST,
	input wire CE,
	// serial management bus
	input wire SCL,
	input wire SDA_IN,
	output wire SDA_OUT,
	output wire SDA_OE,
	// event sources
	input wire TOUCH_DETECT,
	input wire PUSHBUTTON_INPUT,
	input wire AC_PRESENT,
	input wire USB_PRESENT,
	// charger state
	input wire THERMAL_REG,
	input wire PATH_LOOP_ENGAGED,
	input wire THERMAL_SUSPEND,
	input wire TERM_CURRENT,
	input wire CHG_TIMEOUT,
	input wire PRECHG_TIMEOUT,
	input wire TEMP_SENSOR_FAULT,
	input wire SUPPLY_LOW_LOCKOUT,
	// interrupt
	output wire INT_N
);

localparam [2:0] S_IDLE = 3'h0;
localparam [2:0] S_ADDR = 3'h1;
localparam [2:0] S_AACK = 3'h2;
localparam [2:0] S_WBYTE = 3'h3;
localparam [2:0] S_WACK = 3'h4;
localparam [2:0] S_RBYTE = 3'h5;
localparam [2:0] S_RACK = 3'h6;

// ****************************************
// pin synchronisation
// ****************************************
wire [13:0] raw;
wire [13:0] syn;
assign raw = {SCL, SDA_IN, TOUCH_DETECT, PUSHBUTTON_INPUT, AC_PRESENT,
	USB_PRESENT, THERMAL_REG, PATH_LOOP_ENGAGED, THERMAL_SUSPEND,
	TERM_CURRENT, CHG_TIMEOUT, PRECHG_TIMEOUT, TEMP_SENSOR_FAULT,
	SUPPLY_LOW_LOCKOUT};

pin_sync #(
	.W(14)
) u_sync (
	.CLK(CLK),
	.RST(RST),
	.CE(CE),
	.D(raw),
	.Q(syn)
);

wire scl_s = syn[13];
wire sda_s = syn[12];
wire touch_s = syn[11];
wire pb_s = syn[10];
wire ac_s = syn[9];
wire usb_s = syn[8];
wire lockout_s = syn[0];

// ****************************************
// charger status, live view
// ****************************************
reg [7:0] stat_r;
wire [7:0] stat_nxt;
assign stat_nxt[`STAT_BIT_THERMAL_REG] = syn[7];
assign stat_nxt[`STAT_BIT_PATH_LOOP] = syn[6];
assign stat_nxt[`STAT_BIT_THERMAL_SUSP] = syn[5];
assign stat_nxt[`STAT_BIT_TERM_CURRENT] = syn[4];
assign stat_nxt[`STAT_BIT_UNUSED] = 1'b0;
assign stat_nxt[`STAT_BIT_CHG_TIMEOUT] = syn[3];
assign stat_nxt[`STAT_BIT_PRECHG_TIMEOUT] = syn[2];
assign stat_nxt[`STAT_BIT_TEMP_FAULT] = syn[1];

// ****************************************
// event edges
// ****************************************
reg touch_p_r;
reg pb_p_r;
reg ac_p_r;
reg usb_p_r;
wire pb_act = PB_ACTIVE_HIGH ? pb_s : ~pb_s;
wire [7:0] ev_set;
assign ev_set[7:4] = 4'h0;
assign ev_set[`EVT_BIT_TOUCH_FLAG] = touch_s & ~touch_p_r;
assign ev_set[`EVT_BIT_BUTTON_FLAG] = pb_act & ~pb_p_r;
assign ev_set[`EVT_BIT_APPLIED_FLAG] = (ac_s & ~ac_p_r) |
	(usb_s & ~usb_p_r);
assign ev_set[`EVT_BIT_REMOVED_FLAG] = (~ac_s & ac_p_r) |
	(~usb_s & usb_p_r);

// ****************************************
// serial slave state
// ****************************************
reg scl_p_r;
reg sda_p_r;
reg [2:0] st_r;
reg [2:0] st_nxt;
reg [3:0] bitc_r;
reg [3:0] bitc_nxt;
reg [7:0] shf_r;
reg [7:0] shf_nxt;
reg [7:0] ptr_r;
reg [7:0] ptr_nxt;
reg first_r;
reg first_nxt;
reg rw_r;
reg rw_nxt;
reg nack_r;
reg nack_nxt;
reg sda_oe_r;
reg sda_oe_nxt;
reg sda_out_r;
reg int_n_r;
reg [7:0] evt_r;
reg [7:0] evt_nxt;
reg [7:0] sent;
reg [7:0] rd_data;

wire scl_rise = scl_s & ~scl_p_r;
wire scl_fall = ~scl_s & scl_p_r;
wire start_c = scl_s & scl_p_r & sda_p_r & ~sda_s;
wire stop_c = scl_s & scl_p_r & ~sda_p_r & sda_s;

always @* begin
	case (ptr_r)
		`EVT_REG_OFFSET: rd_data = evt_r;
		`STAT_REG_OFFSET: rd_data = stat_r;
		default: rd_data = `UNMAPPED_READ;
	endcase
end

// ****************************************
// bus sequencing and register update
// ****************************************
always @* begin
	st_nxt = st_r;
	bitc_nxt = bitc_r;
	shf_nxt = shf_r;
	ptr_nxt = ptr_r;
	first_nxt = first_r;
	rw_nxt = rw_r;
	nack_nxt = nack_r;
	sda_oe_nxt = sda_oe_r;
	sent = 8'h00;
	evt_nxt = evt_r;
	if (start_c) begin
		st_nxt = S_ADDR;
		bitc_nxt = 4'h0;
		first_nxt = 1'b1;
		sda_oe_nxt = 1'b0;
	end else if (stop_c) begin
		st_nxt = S_IDLE;
		sda_oe_nxt = 1'b0;
	end else begin
		case (st_r)
			S_ADDR, S_WBYTE: begin
				if (scl_rise && bitc_r != `BITS_PER_BYTE) begin
					shf_nxt = {shf_r[6:0], sda_s};
					bitc_nxt = bitc_r + 4'h1;
				end else if (scl_fall && bitc_r == `BITS_PER_BYTE) begin
					if (st_r == S_ADDR) begin
						if (shf_r[7:1] == DEV_ADDR) begin
							st_nxt = S_AACK;
							rw_nxt = shf_r[0];
							sda_oe_nxt = 1'b1;
						end else begin
							st_nxt = S_IDLE;
						end
					end else begin
						st_nxt = S_WACK;
						sda_oe_nxt = 1'b1;
						if (first_r) begin
							ptr_nxt = shf_r;
							first_nxt = 1'b0;
						end else begin
							// status writes fall through unused
							if (ptr_r == `EVT_REG_OFFSET)
								evt_nxt = (evt_r & `EVT_FLAG_MASK) |
									(shf_r & `EVT_IRQ_EN_MASK);
							ptr_nxt = ptr_r + 8'h01;
						end
					end
				end
			end
			S_AACK, S_RACK: begin
				if (scl_rise)
					nack_nxt = sda_s & (st_r == S_RACK);
				if (scl_fall) begin
					bitc_nxt = 4'h0;
					if (!rw_r) begin
						st_nxt = S_WBYTE;
						sda_oe_nxt = 1'b0;
					end else if (nack_r && st_r == S_RACK) begin
						st_nxt = S_IDLE;
						sda_oe_nxt = 1'b0;
					end else begin
						// flags are cleared once latched for shifting out
						st_nxt = S_RBYTE;
						shf_nxt = rd_data;
						sda_oe_nxt = ~rd_data[7];
						ptr_nxt = ptr_r + 8'h01;
						if (ptr_r == `EVT_REG_OFFSET)
							sent = evt_r & `EVT_FLAG_MASK;
					end
				end
			end
			S_WACK: begin
				if (scl_fall) begin
					st_nxt = S_WBYTE;
					bitc_nxt = 4'h0;
					sda_oe_nxt = 1'b0;
				end
			end
			S_RBYTE: begin
				if (scl_rise)
					bitc_nxt = bitc_r + 4'h1;
				if (scl_fall) begin
					if (bitc_r == `BITS_PER_BYTE) begin
						st_nxt = S_RACK;
						sda_oe_nxt = 1'b0;
						nack_nxt = 1'b0;
					end else begin
						shf_nxt = {shf_r[6:0], 1'b0};
						sda_oe_nxt = ~shf_r[6];
					end
				end
			end
			default: begin
				st_nxt = S_IDLE;
			end
		endcase
	end
	// set wins over a clear in the same cycle
	evt_nxt = (evt_nxt & ~sent) | ev_set;
end

// ****************************************
// registers
// ****************************************
always @(posedge CLK) begin
	if (RST || (CE && lockout_s)) begin
		st_r <= S_IDLE;
		bitc_r <= 4'h0;
		shf_r <= 8'h00;
		ptr_r <= `PTR_RESET;
		first_r <= 1'b0;
		rw_r <= 1'b0;
		nack_r <= 1'b0;
		sda_oe_r <= 1'b0;
		sda_out_r <= 1'b0;
		evt_r <= `EVT_RESET;
		stat_r <= `STAT_RESET;
		int_n_r <= 1'b1;
		scl_p_r <= 1'b1;
		sda_p_r <= 1'b1;
		touch_p_r <= 1'b0;
		// synchroniser reads 0 after reset, which is the active level
		// of a low-active button; start high so no false press is seen
		pb_p_r <= 1'b1;
		ac_p_r <= 1'b0;
		usb_p_r <= 1'b0;
	end else if (CE) begin
		st_r <= st_nxt;
		bitc_r <= bitc_nxt;
		shf_r <= shf_nxt;
		ptr_r <= ptr_nxt;
		first_r <= first_nxt;
		rw_r <= rw_nxt;
		nack_r <= nack_nxt;
		sda_oe_r <= sda_oe_nxt;
		sda_out_r <= 1'b0;
		evt_r <= evt_nxt;
		stat_r <= stat_nxt;
		int_n_r <= ~((evt_r[`EVT_BIT_INPUT_IRQ_EN] &
			(evt_r[`EVT_BIT_APPLIED_FLAG] |
			evt_r[`EVT_BIT_REMOVED_FLAG])) |
			(evt_r[`EVT_BIT_TOUCH_IRQ_EN] &
			evt_r[`EVT_BIT_TOUCH_FLAG]) |
			(evt_r[`EVT_BIT_BUTTON_IRQ_EN] &
			evt_r[`EVT_BIT_BUTTON_FLAG]));
		scl_p_r <= scl_s;
		sda_p_r <= sda_s;
		touch_p_r <= touch_s;
		pb_p_r <= pb_act;
		ac_p_r <= ac_s;
		usb_p_r <= usb_s;
	end
end

assign SDA_OUT = sda_out_r;
assign SDA_OE = sda_oe_r;
assign INT_N = int_n_r;

endmodule // pmic_status_regs

// ---- sim/i2c_host.sv ----
`timescale 1ns/10ps
module i2c_host #(
	parameter logic [6:0] ADDR = 7'h2a
) (
	// bus
	input wire clk,
	input wire sda_oe,
	input wire sda_o,
	output logic scl,
	output logic sda
);
	// ***
	// phases
	// ***
	logic drv = 1'b1;
	logic [6:0] dev = ADDR;
	initial scl = 1'b1;
	// released line floats up on its pull-up
	assign sda = drv & (sda_oe ? sda_o : 1'b1);
	// five cycles a phase, above the four the slave needs
	task automatic p(input logic c, s);
		scl = c;
		drv = s;
		repeat (5) @(negedge clk);
	endtask
	task automatic xb(input logic [7:0] d, output logic [7:0] r,
		output logic a);
		for (int i = 8; i >= 0; i--) begin
			p(1'b0, i ? d[i-1] : 1'b1);
			p(1'b1, drv);
			if (i)
				r[i-1] = sda;
			else
				a = sda;
			p(1'b1, drv);
			p(1'b0, drv);
		end
	endtask
	task automatic start;
		p(1'b0, 1'b1);
		p(1'b1, 1'b1);
		p(1'b1, 1'b0);
		p(1'b0, 1'b0);
	endtask
	task automatic stop;
		p(1'b0, 1'b0);
		p(1'b1, 1'b0);
		p(1'b1, 1'b1);
	endtask
	task automatic wr(input logic [7:0] a, d, output logic n);
		logic [7:0] r;
		logic k;
		start;
		xb({dev, 1'b0}, r, n);
		xb(a, r, k);
		xb(d, r, k);
		stop;
	endtask
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		logic [7:0] r;
		logic k;
		start;
		xb({dev, 1'b0}, r, k);
		xb(a, r, k);
		start;
		xb({dev, 1'b1}, r, k);
		xb(8'hff, d, k);
		stop;
	endtask
endmodule // i2c_host

// ---- sim/status_monitor.sv ----
`timescale 1ns/10ps
module status_monitor (
	// clock
	input wire CLK,
	input wire RST,
	// pins
	input wire SCL,
	input wire TOUCH_DETECT,
	input wire PUSHBUTTON_INPUT,
	input wire AC_PRESENT,
	input wire USB_PRESENT,
	input wire SUPPLY_LOW_LOCKOUT,
	input wire SDA_OE,
	input wire INT_N
);
	// ***
	// helpers
	// ***
	logic [5:0] ev, ev_q;
	logic [3:0] quiet, since_fall;
	assign ev = {TOUCH_DETECT, PUSHBUTTON_INPUT, AC_PRESENT,
		USB_PRESENT, SCL, SUPPLY_LOW_LOCKOUT};
	always @(posedge CLK) begin
		ev_q <= ev;
		if (RST || ev != ev_q)
			quiet <= 4'h0;
		else if (quiet != 4'hf)
			quiet <= quiet + 4'h1;
		if (RST || (ev_q[1] && !ev[1]))
			since_fall <= 4'h0;
		else if (since_fall != 4'hf)
			since_fall <= since_fall + 4'h1;
	end
	default clocking cb @(posedge CLK); endclocking
	default disable iff (RST);
	sequence lock_seen;
		$rose(SUPPLY_LOW_LOCKOUT) ##1 SUPPLY_LOW_LOCKOUT;
	endsequence
	a_reset_leaves_idle: assert property ($fell(RST) |-> INT_N && !SDA_OE)
		else $error("not idle after reset");
	a_lockout_clears_all: assert property (
		lock_seen |-> ##[0:3] (INT_N && !SDA_OE)) else $error("lockout kept");
	a_lockout_holds_idle: assert property (
		SUPPLY_LOW_LOCKOUT [*4] |-> INT_N && !SDA_OE) else $error("lock busy");
	a_release_stays_idle: assert property (
		$fell(SUPPLY_LOW_LOCKOUT) |-> INT_N [*3]) else $error("int at release");
	a_int_fall_caused: assert property (
		$fell(INT_N) |-> quiet < 4'h8) else $error("int without cause");
	a_int_clear_caused: assert property (
		$rose(INT_N) |-> quiet < 4'h8) else $error("int cleared alone");
	a_oe_after_fall: assert property (
		$changed(SDA_OE) |-> since_fall inside {[1:6]}) else $error("oe moved");
	a_oe_steady_high: assert property (
		SCL [*2] |-> $stable(SDA_OE)) else $error("oe moved in high");
endmodule // status_monitor
bind pmic_status_regs status_monitor u_mon (.CLK(CLK), .RST(RST),
	.SCL(SCL), .TOUCH_DETECT(TOUCH_DETECT),
	.PUSHBUTTON_INPUT(PUSHBUTTON_INPUT), .AC_PRESENT(AC_PRESENT),
	.USB_PRESENT(USB_PRESENT), .SUPPLY_LOW_LOCKOUT(SUPPLY_LOW_LOCKOUT),
	.SDA_OE(SDA_OE), .INT_N(INT_N));

// ---- sim/tb.sv ----
`timescale 1ns/10ps
`include "pmic_status_defines.vh"
module tb;
	// ***
	// wiring
	// ***
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic lock = 1'b0;
	logic [3:0] pin = 4'h4;
	logic [6:0] st = 7'h00;
	logic [3:0] sq [5] = '{4'hc, 4'h0, 4'h6, 4'h7, 4'h4};
	logic [7:0] fx [5] = '{8'h08, 8'h04, 8'h02, 8'h02, 8'h01};
	logic [7:0] d;
	logic k;
	int fails = 0;
	int cmp_count = 0;
	wire scl, sda, oe, so, int_n;
	localparam logic [7:0] EV = `EVT_REG_OFFSET;
	localparam logic [7:0] SR = `STAT_REG_OFFSET;
	initial forever #5 clk = ~clk;
	pmic_status_regs uut (.CLK(clk), .RST(rst), .CE(1'b1), .SCL(scl),
		.SDA_IN(sda), .SDA_OUT(so), .SDA_OE(oe), .TOUCH_DETECT(pin[3]),
		.PUSHBUTTON_INPUT(pin[2]), .AC_PRESENT(pin[1]),
		.USB_PRESENT(pin[0]), .THERMAL_REG(st[6]),
		.PATH_LOOP_ENGAGED(st[5]), .THERMAL_SUSPEND(st[4]),
		.TERM_CURRENT(st[3]), .CHG_TIMEOUT(st[2]),
		.PRECHG_TIMEOUT(st[1]), .TEMP_SENSOR_FAULT(st[0]),
		.SUPPLY_LOW_LOCKOUT(lock), .INT_N(int_n));
	i2c_host host (.clk(clk), .sda_oe(oe), .sda_o(so), .scl(scl),
		.sda(sda));
	task automatic chk(input logic [7:0] g, e);
		cmp_count++;
		if (g !== e) begin
			fails++;
			$display("unexpected %0t got %h want %h", $time, g, e);
		end
	endtask
	task automatic rdc(input logic [7:0] a, e);
		host.rd(a, d);
		chk(d, e);
	endtask
	// events land a few cycles after the pin moves
	task automatic w;
		repeat (8) @(negedge clk);
	endtask
	task automatic final_report;
		if (fails == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial begin
		repeat (6) @(negedge clk);
		rst = 1'b0;
		w;
		chk({7'h0, int_n}, 8'h01);
		rdc(EV, 8'h00);
		for (int i = 0; i < 7; i++) begin
			st = 7'h1 << i;
			w;
			rdc(SR, {st[6:3], 1'b0, st[2:0]});
		end
		st = 7'h7f;
		host.wr(SR, 8'h00, k);
		rdc(SR, 8'hf7);
		rdc(8'h10, 8'h00);
		for (int i = 0; i < 5; i++) begin
			pin = sq[i];
			w;
			rdc(EV, fx[i]);
		end
		rdc(EV, 8'h00);
		host.wr(EV, 8'hff, k);
		rdc(EV, 8'he0);
		pin = 4'h5;
		w;
		chk({7'h0, int_n}, 8'h00);
		rdc(EV, 8'he2);
		w;
		chk({7'h0, int_n}, 8'h01);
		pin = 4'h4;
		w;
		chk({7'h0, int_n}, 8'h00);
		rdc(EV, 8'he1);
		host.wr(EV, 8'h00, k);
		pin = 4'hc;
		w;
		chk({7'h0, int_n}, 8'h01);
		host.wr(EV, 8'h40, k);
		chk({7'h0, int_n}, 8'h00);
		pin = 4'h4;
		lock = 1'b1;
		w;
		lock = 1'b0;
		w;
		chk({7'h0, int_n}, 8'h01);
		rdc(EV, 8'h00);
		final_report;
	end
	initial begin
		repeat (50000) @(posedge clk);
		fails++;
		$display("unexpected %0t timeout", $time);
		final_report;
	end
endmodule // tb
